/* hdl/ptc_pkg.sv */
// Package for the periodic tick counter: register map, bit fields,
// reset values and the register bus carrier.
// Assumes an 8-bit register port with 16-bit byte addresses.
package ptc_pkg;

    ////////////////////////////////////////////////////////////////////
    // Register map
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int CNT_W_DEF = 8;
    localparam int SRC_N = 4;
    localparam logic [ADDR_W-1:0] OFF_CTL = 16'h5000;
    localparam logic [ADDR_W-1:0] OFF_CNT = 16'h5001;
    localparam logic [ADDR_W-1:0] OFF_ENA = 16'h5002;
    localparam logic [ADDR_W-1:0] OFF_CAUSE = 16'h5003;

    ////////////////////////////////////////////////////////////////////
    // Field positions in the control register
    localparam int BIT_RUN = 0;
    localparam int BIT_CLR = 4;

    // Counter bits that feed the 32, 8, 2 and 1 Hz causes
    localparam int BIT_32HZ = 2;
    localparam int BIT_8HZ = 4;
    localparam int BIT_2HZ = 6;
    localparam int BIT_1HZ = 7;

    // Cause and enable positions
    localparam int SRC_32HZ = 3;
    localparam int SRC_8HZ = 2;
    localparam int SRC_2HZ = 1;
    localparam int SRC_1HZ = 0;

    ////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
    localparam logic [SRC_N-1:0] RST_SRC = 4'h0;

    typedef struct packed {
        logic wrStb;
        logic rdStb;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wrData;
    } ptc_bus_req_t;

endpackage : ptc_pkg

/* hdl/ptc_periodic_tick_counter.sv */
// Periodic tick counter: 8-bit up-counter on a 256 Hz tick, run/stop
// synchronised to the tick, four rate causes with enables and W1C flags.
// Assumes tick256 is a slow level synchronous to mclk and that the
// interrupt controller samples irqReq as a level.
//
// Functional notes
// - Writing 1 to clear bit zeroes the counter; 0 does nothing
// - Counter is zero after system reset
// - Run bit 1 lets counter advance on tick; 0 halts it
// - Stopping keeps the value; running again resumes from it
// - Run and clear written together: clear first, then count
// - Clear while running keeps counting from zero; stopped stays zero
// - Clear bit always reads back as zero
// - Run and stop take effect at next falling tick edge
// - After stop request counter advances once more, then halts
// - Run bit reads 1 until counter has truly stopped
// - While running, falling edges of 32/8/2/1 Hz raise causes
// - Enable register: bit3 32Hz, bit2 8Hz, bit1 2Hz, bit0 1Hz
// - Cause register: bit3 32Hz, bit2 8Hz, bit1 2Hz, bit0 1Hz
// - Cause flag sets only if its enable is 1
// - One shared request output, high while any cause flag is 1
// - Reserved bits read 0, are written 0; registers are 8 bits
// - Counter is 8-bit binary, advanced by 256 Hz tick
// - Bit0 is 128 Hz, bit7 1 Hz; sources are bits 2,4,6,7
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module ptc_periodic_tick_counter #(
    parameter int CNT_W = ptc_pkg::CNT_W_DEF
) (
    input wire logic mclk,
    input wire logic rst,
    input wire ptc_pkg::ptc_bus_req_t busReq,
    output logic [ptc_pkg::DATA_W-1:0] rdData,
    input wire logic tick256,
    output logic irqReq
);
    import ptc_pkg::*;

    if (CNT_W != DATA_W) begin : g_chk
        $error("CNT_W must equal the register width");
    end

    ////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [SRC_N-1:0] srcBits(
        input logic [CNT_W-1:0] c
    );
        logic [SRC_N-1:0] s;
        s = RST_SRC;
        s[SRC_32HZ] = c[BIT_32HZ];
        s[SRC_8HZ] = c[BIT_8HZ];
        s[SRC_2HZ] = c[BIT_2HZ];
        s[SRC_1HZ] = c[BIT_1HZ];
        return s;
    endfunction : srcBits

    ////////////////////////////////////////////////////////////////////
    // State
    logic tickPrev_r;
    logic runReq_r;
    logic running_r;
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic [SRC_N-1:0] enable_r;
    logic [SRC_N-1:0] cause_r;
    logic [SRC_N-1:0] cause_nxt;
    logic [DATA_W-1:0] rdData_r;
    logic [DATA_W-1:0] rdData_nxt;

    ////////////////////////////////////////////////////////////////////
    // Address decode
    wire logic selCtl = (busReq.addr == OFF_CTL);
    wire logic selCnt = (busReq.addr == OFF_CNT);
    wire logic selEna = (busReq.addr == OFF_ENA);
    wire logic selCause = (busReq.addr == OFF_CAUSE);
    wire logic wrCtl = busReq.wrStb && selCtl;
    wire logic wrEna = busReq.wrStb && selEna;
    wire logic wrCause = busReq.wrStb && selCause;
    wire logic clrCmd = wrCtl && busReq.wrData[BIT_CLR];
    wire logic [SRC_N-1:0] w1cMask =
        wrCause ? busReq.wrData[SRC_N-1:0] : RST_SRC;

    ////////////////////////////////////////////////////////////////////
    // Tick edge and run synchronisation
    // Falling edge turned into a one-cycle enable, no second clock
    wire logic tickFall = tickPrev_r && !tick256;

    // Request applied only at the tick edge
    wire logic running_nxt =
        tickFall ? runReq_r : running_r;

    // Advance uses the state before the edge, so a stop request
    // still gets one last step
    wire logic advance = tickFall && running_r;

    wire logic [CNT_W-1:0] countInc = CNT_W'(count_r + 1'b1);

    // Clear wins over the step in the same cycle
    always_comb begin
        if (clrCmd) begin
            count_nxt = '0;
        end else if (advance) begin
            count_nxt = countInc;
        end else begin
            count_nxt = count_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Causes
    // A fall is only a real step of the counter, never a clear
    wire logic [SRC_N-1:0] srcFall =
        advance ? (srcBits(count_r) & ~srcBits(countInc))
                : RST_SRC;
    wire logic [SRC_N-1:0] causeSet = srcFall & enable_r;

    // Set wins over a W1C clear in the same cycle
    assign cause_nxt = (cause_r & ~w1cMask) | causeSet;

    ////////////////////////////////////////////////////////////////////
    // Read mux
    // Run bit stays 1 until the stop has happened at the tick
    wire logic runRead = runReq_r || running_r;
    wire logic [DATA_W-1:0] ctlRead =
        {{(DATA_W-1){1'b0}}, runRead};
    wire logic [DATA_W-1:0] enaRead =
        {{(DATA_W-SRC_N){1'b0}}, enable_r};
    wire logic [DATA_W-1:0] causeRead =
        {{(DATA_W-SRC_N){1'b0}}, cause_r};

    always_comb begin
        if (!busReq.rdStb) begin
            rdData_nxt = RST_BYTE;
        end else if (selCtl) begin
            rdData_nxt = ctlRead;
        end else if (selCnt) begin
            rdData_nxt = count_r;
        end else if (selEna) begin
            rdData_nxt = enaRead;
        end else if (selCause) begin
            rdData_nxt = causeRead;
        end else begin
            rdData_nxt = RST_BYTE;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tickPrev_r <= 1'b0;
            running_r <= 1'b0;
            count_r <= '0;
        end else begin
            tickPrev_r <= tick256;
            running_r <= running_nxt;
            count_r <= count_nxt;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            runReq_r <= 1'b0;
        end else if (wrCtl) begin
            runReq_r <= busReq.wrData[BIT_RUN];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            enable_r <= RST_SRC;
        end else if (wrEna) begin
            enable_r <= busReq.wrData[SRC_N-1:0];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cause_r <= RST_SRC;
            rdData_r <= RST_BYTE;
            irqReq <= 1'b0;
        end else begin
            cause_r <= cause_nxt;
            rdData_r <= rdData_nxt;
            irqReq <= |cause_nxt;
        end
    end

    assign rdData = rdData_r;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    a_clear_zero: assert property (
        clrCmd |=> count_r == '0
    ) else $error("counter not zero after clear write");

    a_clear_reads: assert property (
        busReq.rdStb && selCtl |=> rdData[DATA_W-1:1] == '0
    ) else $error("control reserved or clear bit read nonzero");

    a_hold_stopped: assert property (
        !running_r && !clrCmd |=> count_r == $past(count_r)
    ) else $error("counter moved while stopped");

    a_run_waits: assert property (
        wrCtl && !tickFall |=> running_r == $past(running_r)
    ) else $error("run state changed without tick edge");

    a_last_step: assert property (
        running_r && !runReq_r && tickFall && !clrCmd
        |=> !running_r && count_r == CNT_W'($past(count_r) + 1'b1)
    ) else $error("stop did not take one last step");

    a_run_readback: assert property (
        busReq.rdStb && selCtl && running_r |=> rdData[BIT_RUN]
    ) else $error("run bit read 0 while still running");

    a_cause_gated: assert property (
        enable_r == RST_SRC && !wrCause |=> cause_r == $past(cause_r)
    ) else $error("cause set with enable off");

    a_cause_1hz: assert property (
        advance && enable_r[SRC_1HZ] && count_r[BIT_1HZ]
        && count_r[BIT_1HZ-1:0] == '1 |=> cause_r[SRC_1HZ]
    ) else $error("1 Hz fall did not set cause");

    a_irq_level: assert property (
        ##1 irqReq == (cause_r != RST_SRC)
    ) else $error("request does not follow causes");

    a_run_clear: assert property (
        wrCtl && busReq.wrData[BIT_CLR] && busReq.wrData[BIT_RUN]
        |=> count_r == '0 && runReq_r
    ) else $error("run with clear did not zero and arm");

    ////////////////////////////////////////////////////////////////////
    // Counter and run state
    a_reset_zero: assert property (
        $fell(rst) |-> count_r == '0 && !running_r && cause_r == RST_SRC
    ) else $error("state not cleared by system reset");

    a_stopped_clear: assert property (
        clrCmd && !running_r && !tickFall |=> count_r == '0 && !running_r
    ) else $error("clear while stopped did not hold zero");

    a_clear_keeps_run: assert property (
        clrCmd && running_r && !tickFall |=> running_r
    ) else $error("clear while running stopped the counter");

    a_run_applies: assert property (
        tickFall |=> running_r == $past(runReq_r)
    ) else $error("run request not applied at tick edge");

    a_step_one: assert property (
        advance && !clrCmd |=> count_r == CNT_W'($past(count_r) + 1'b1)
    ) else $error("counter did not step by one");

    a_tick_only: assert property (
        !tickFall && !clrCmd |=> count_r == $past(count_r)
    ) else $error("counter moved without tick edge");

    a_tick_pulse: assert property (
        tickFall |=> !tickFall
    ) else $error("tick enable longer than one cycle");

    a_zero_clear_nop: assert property (
        wrCtl && !busReq.wrData[BIT_CLR] && !advance
        |=> count_r == $past(count_r)
    ) else $error("clear bit 0 changed the counter");

    a_run_arm: assert property (
        wrCtl |=> runReq_r == $past(busReq.wrData[BIT_RUN])
    ) else $error("run request not taken from write");

    a_stays_stopped: assert property (
        !running_r && !runReq_r |=> !running_r
    ) else $error("counter started without run request");

    ////////////////////////////////////////////////////////////////////
    // Register port
    a_ctl_idle_read: assert property (
        busReq.rdStb && selCtl && !runReq_r && !running_r
        |=> rdData == RST_BYTE
    ) else $error("stopped control register read nonzero");

    a_run_req_read: assert property (
        busReq.rdStb && selCtl && runReq_r |=> rdData[BIT_RUN]
    ) else $error("run bit read 0 after run write");

    a_cnt_read: assert property (
        busReq.rdStb && selCnt |=> rdData == $past(count_r)
    ) else $error("count read does not match counter");

    a_ena_read: assert property (
        busReq.rdStb && selEna |=> rdData[DATA_W-1:SRC_N] == '0
        && rdData[SRC_N-1:0] == $past(enable_r)
    ) else $error("enable register read wrong");

    a_cause_read: assert property (
        busReq.rdStb && selCause |=> rdData[DATA_W-1:SRC_N] == '0
        && rdData[SRC_N-1:0] == $past(cause_r)
    ) else $error("cause register read wrong");

    a_ena_write: assert property (
        wrEna |=> enable_r == $past(busReq.wrData[SRC_N-1:0])
    ) else $error("enable write not stored");

    a_cnt_ro: assert property (
        busReq.wrStb && selCnt && !advance |=> count_r == $past(count_r)
    ) else $error("write to count register changed it");

    a_unmapped_read: assert property (
        busReq.rdStb && !selCtl && !selCnt && !selEna && !selCause
        |=> rdData == RST_BYTE
    ) else $error("unmapped read returned nonzero");

    ////////////////////////////////////////////////////////////////////
    // Causes and request
    a_w1c_clears: assert property (
        wrCause && !advance |=> (cause_r & $past(w1cMask)) == RST_SRC
    ) else $error("cause not cleared by writing 1");

    a_w0_keeps: assert property (
        wrCause && !advance
        |=> (cause_r | $past(w1cMask)) == ($past(cause_r) | $past(w1cMask))
    ) else $error("cause changed by writing 0");

    a_set_sticks: assert property (
        advance |=> (cause_r & $past(causeSet)) == $past(causeSet)
    ) else $error("cause set lost in same cycle as clear");

    a_cause_32hz: assert property (
        advance && enable_r[SRC_32HZ] && count_r[BIT_32HZ:0] == '1
        |=> cause_r[SRC_32HZ]
    ) else $error("32 Hz fall did not set cause");

    a_cause_8hz: assert property (
        advance && enable_r[SRC_8HZ] && count_r[BIT_8HZ:0] == '1
        |=> cause_r[SRC_8HZ]
    ) else $error("8 Hz fall did not set cause");

    a_cause_2hz: assert property (
        advance && enable_r[SRC_2HZ] && count_r[BIT_2HZ:0] == '1
        |=> cause_r[SRC_2HZ]
    ) else $error("2 Hz fall did not set cause");

    a_cause_on_step: assert property (
        !advance |=> (cause_r & ~$past(cause_r)) == RST_SRC
    ) else $error("cause set without counter step");

    a_cause_enabled: assert property (
        ##1 (cause_r & ~$past(cause_r) & ~$past(enable_r)) == RST_SRC
    ) else $error("cause set for a disabled source");

    a_irq_rise: assert property (
        $rose(irqReq) |-> $past(advance)
    ) else $error("request rose without counter step");

    a_irq_fall: assert property (
        $fell(irqReq) |-> $past(wrCause)
    ) else $error("request fell without cause write");

    ////////////////////////////////////////////////////////////////////
    // Covers
    c_count_wrap: cover property (advance && count_r == '1);
    c_stop_seq: cover property (
        running_r && !runReq_r ##[1:1000] !running_r
    );
    c_cause_set: cover property (causeSet != RST_SRC);
    c_clear_running: cover property (clrCmd && running_r);
    c_set_vs_clear: cover property ((causeSet & w1cMask) != RST_SRC);

endmodule : ptc_periodic_tick_counter

/* test/ptc_irq_ctrl_model.sv */
// Interrupt controller model seen by the tick counter's request line.
// Assumes irqReq is a level synchronous to mclk.
`timescale 1ns/1ps
module ptc_irq_ctrl_model #(
    parameter int VEC_NUM = 7
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic irqReq,
    input wire logic srcEnable,
    output logic pendingFlag,
    output logic cpuReq,
    output logic [7:0] vecNum
);
    ////////////////////////////////////////////////////////////////////
    // Level trigger: pending follows the source, so W1C there clears it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pendingFlag <= 1'b0;
        end else begin
            pendingFlag <= irqReq;
        end
    end
    assign cpuReq = pendingFlag & srcEnable;
    assign vecNum = cpuReq ? 8'(VEC_NUM) : 8'h00;
endmodule : ptc_irq_ctrl_model

/* test/tb_top.sv */
// Self-checking bench for the periodic tick counter.
// Bench drives bus and tick; reads are checked from a queue.
`timescale 1ns/1ps
module tb_top;
    import ptc_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic tick256 = 1'b0;
    logic srcEnable = 1'b1;
    logic irqReq, pendingFlag, cpuReq, rdPend;
    logic [7:0] rdData, vecNum;
    ptc_bus_req_t busReq = '0;
    logic [7:0] expQ[$];
    logic [31:0] seed = 32'h76b99877;
    int error_cnt = 0;
    int tests_run = 0;
    always #2.5 mclk = ~mclk;
    ptc_periodic_tick_counter ptc_periodic_tick_counter_inst (.mclk(mclk),
        .rst(rst), .busReq(busReq), .rdData(rdData), .tick256(tick256),
        .irqReq(irqReq));
    ptc_irq_ctrl_model ptc_irq_ctrl_model_inst (.mclk(mclk), .rst(rst),
        .irqReq(irqReq), .srcEnable(srcEnable), .pendingFlag(pendingFlag),
        .cpuReq(cpuReq), .vecNum(vecNum));
    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task automatic chk(input logic [7:0] g, input logic [7:0] x);
        tests_run++;
        if (g !== x) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, g, x);
        end
    endtask : chk
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge mclk);
        busReq <= '{wrStb: 1'b1, rdStb: 1'b0, addr: a, wrData: d};
        @(posedge mclk);
        busReq.wrStb <= 1'b0;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] x);
        expQ.push_back(x);
        @(posedge mclk);
        busReq <= '{wrStb: 1'b0, rdStb: 1'b1, addr: a, wrData: 8'h00};
        @(posedge mclk);
        busReq.rdStb <= 1'b0;
    endtask : rd
    // Each call gives n falling edges; tick stays low afterwards
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge mclk);
            tick256 <= 1'b1;
            repeat (2) @(posedge mclk);
            tick256 <= 1'b0;
            repeat (2) @(posedge mclk);
        end
    endtask : ticks
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////////
    // Read data stands only in the cycle after the strobe
    always @(posedge mclk) begin
        if (rdPend === 1'b1) chk(rdData, expQ.pop_front());
        rdPend <= busReq.rdStb;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++) rd(OFF_CTL + 16'(i), RST_BYTE);
        repeat (4) begin
            seed = xs(seed);
            wr(OFF_ENA, seed[7:0] & 8'h0f);
            rd(OFF_ENA, seed[7:0] & 8'h0f);
            wr(OFF_CNT, seed[15:8]);
            rd(OFF_CNT, 8'h00);
        end
        wr(OFF_CAUSE, 8'h0f);
        wr(OFF_ENA, 8'h00);
        ticks(2);
        rd(OFF_CNT, 8'h00);
        wr(OFF_CTL, 8'h11);
        rd(OFF_CTL, 8'h01);
        ticks(1);
        rd(OFF_CNT, 8'h00);
        ticks(5);
        rd(OFF_CNT, 8'h05);
        wr(OFF_CTL, 8'h00);
        rd(OFF_CTL, 8'h01);
        ticks(1);
        rd(OFF_CNT, 8'h06);
        rd(OFF_CTL, 8'h00);
        ticks(3);
        rd(OFF_CNT, 8'h06);
        wr(OFF_CTL, 8'h01);
        ticks(3);
        rd(OFF_CNT, 8'h08);
        wr(OFF_CTL, 8'h11);
        rd(OFF_CNT, 8'h00);
        ticks(2);
        rd(OFF_CNT, 8'h02);
        wr(OFF_CTL, 8'h00);
        ticks(1);
        wr(OFF_CTL, 8'h10);
        ticks(2);
        rd(OFF_CNT, 8'h00);
        wr(OFF_ENA, 8'h0e);
        wr(OFF_CTL, 8'h11);
        ticks(8);
        rd(OFF_CAUSE, 8'h00);
        chk({7'h00, irqReq}, 8'h00);
        ticks(1);
        rd(OFF_CAUSE, 8'h08);
        chk({7'h00, irqReq}, 8'h01);
        chk(vecNum, 8'h07);
        ticks(248);
        rd(OFF_CNT, 8'h00);
        rd(OFF_CAUSE, 8'h0e);
        wr(OFF_CAUSE, 8'h08);
        rd(OFF_CAUSE, 8'h06);
        wr(OFF_CAUSE, 8'h06);
        rd(OFF_CAUSE, 8'h00);
        chk({6'h00, pendingFlag, irqReq}, 8'h00);
        wr(OFF_ENA, 8'h01);
        ticks(256);
        rd(OFF_CAUSE, 8'h01);
        wr(OFF_CAUSE, 8'h01);
        rd(OFF_CAUSE, 8'h00);
        ticks(3);
        rd(OFF_CNT, 8'h03);
        repeat (2) @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rd(OFF_CNT, 8'h00);
        rd(OFF_CTL, 8'h00);
        repeat (4) @(posedge mclk);
        give_verdict();
    end
endmodule : tb_top
